// ---- design/ufc_top.sv ----
// Purpose: UART channel with trigger tables and character format control
// Assumes: APB slave with one wait state, fixed 16x oversampling rate
// Notes:
`timescale 1ns/10ps
`default_nettype none
module ufc_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Interrupt
  output logic irq
);
  import ufc_pkg::*;

  typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PAR, TX_STOP} ufc_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufc_rx_st_t;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Address decode shared by read and write
  function automatic logic ufc_mapped(input logic [7:0] a);
    ufc_mapped = (a[1:0] == 2'h0) && (a <= ADDR_IRQ_MASK);
  endfunction : ufc_mapped

  // Level lookup for one direction
  function automatic logic [7:0] ufc_level(input ufc_tbl_t tbl, input logic [1:0] code,
                                           input logic is_tx, input logic [7:0] prog);
    logic [7:0] lv;
    lv = 8'h01;
    unique case (tbl)
      TBL_A: lv = is_tx ? 8'h01 : (code == 2'h0 ? 8'h01 : code == 2'h1 ? 8'h04 :
                                   code == 2'h2 ? 8'h08 : 8'h0e);
      TBL_B: lv = is_tx ? (code == 2'h0 ? 8'h10 : code == 2'h1 ? 8'h08 :
                           code == 2'h2 ? 8'h18 : 8'h1e)
                        : (code == 2'h0 ? 8'h08 : code == 2'h1 ? 8'h10 :
                           code == 2'h2 ? 8'h18 : 8'h1c);
      TBL_C: lv = is_tx ? (code == 2'h0 ? 8'h08 : code == 2'h1 ? 8'h10 :
                           code == 2'h2 ? 8'h20 : 8'h38)
                        : (code == 2'h0 ? 8'h08 : code == 2'h1 ? 8'h10 :
                           code == 2'h2 ? 8'h38 : 8'h3c);
      TBL_PROG: lv = prog;
    endcase
    ufc_level = lv;
  endfunction : ufc_level

  // Parity over the configured data bits only
  function automatic logic ufc_parity(input logic [7:0] d, input ufc_lfc_t f);
    logic [7:0] m;
    m = d & (8'hff >> (2'h3 - f.wlen));
    if (f.force_par)
      ufc_parity = ~f.par_even;
    else
      ufc_parity = f.par_even ? ^m : ~^m;
  endfunction : ufc_parity

  // ----------------------------------------------------------------
  // Reset release and input synchroniser
  // ----------------------------------------------------------------
  logic rst_m_q, rst_n;
  logic rxd_m_q, rxd_s_q;

  // Two-stage reset release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_m_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_n <= rst_m_q;
    end
  end

  // Line input through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end
    else
    begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Oversample tick divider
  // ----------------------------------------------------------------
  logic [4:0] div_q;
  logic tick_q;

  // One-cycle tick every TICK_DIV clocks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 5'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == TICK_DIV - 5'h01);
      div_q <= (div_q == TICK_DIV - 5'h01) ? 5'h00 : div_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // APB slave and control registers
  // ----------------------------------------------------------------
  ufc_lfc_t lfc_q;
  ufc_trig_t prog_q;
  logic [1:0] rx_code_q, tx_code_q;
  logic [1:0] tbl_q;
  logic ftc_dest_q, fifo_en_q;
  logic [7:0] efe_q;
  logic [IRQ_W-1:0] ist_q, imask_q, iset;
  logic rx_rst_q, tx_rst_q;
  logic wr_go, rd_go;
  logic [31:0] rd_mux;
  logic [6:0] rx_cnt_q, tx_cnt_q;
  logic [7:0] rx_rdata_q;
  logic rx_avail_q, tx_busy;
  ufc_tbl_t tbl;
  logic [7:0] rx_trig, tx_trig;

  assign wr_go = psel & penable & pready & pwrite;
  assign rd_go = psel & penable & pready & ~pwrite;
  assign tbl = ufc_tbl_t'(tbl_q);
  // Both directions read the one table field
  assign rx_trig = ufc_level(tbl, rx_code_q, 1'b0, prog_q.rx);
  assign tx_trig = ufc_level(tbl, tx_code_q, 1'b1, prog_q.tx);

  // Handshake with one wait state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~ufc_mapped(paddr);
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // Read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ADDR_DATA: rd_mux = {24'h000000, rx_avail_q ? rx_rdata_q : 8'h00};
      ADDR_LINE_FORMAT_CONTROL: rd_mux = {24'h000000, lfc_q};
      ADDR_FEATURE_TABLE_CONTROL: rd_mux = {24'h000000, ftc_dest_q, 1'b0, tbl_q, 4'h0};
      ADDR_PROGRAMMABLE_TRIGGER_LEVEL: rd_mux = {24'h000000, ftc_dest_q ? prog_q.tx : prog_q.rx};
      ADDR_ENHANCED_FUNCTION_ENABLE: rd_mux = {24'h000000, efe_q};
      ADDR_LEVEL_STATUS: rd_mux = {14'h0000, fifo_en_q, tx_busy, 1'b0, tx_cnt_q, 1'b0, rx_cnt_q};
      ADDR_IRQ_STATUS: rd_mux = {27'h0000000, ist_q};
      ADDR_IRQ_MASK: rd_mux = {27'h0000000, imask_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Format and trigger configuration writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfc_q <= ufc_lfc_t'(LFC_RESET);
      prog_q <= {TRIG_RESET, TRIG_RESET};
      rx_code_q <= 2'h0;
      tx_code_q <= 2'h0;
      tbl_q <= 2'h0;
      ftc_dest_q <= 1'b0;
      fifo_en_q <= 1'b0;
      efe_q <= 8'h00;
      imask_q <= '0;
      rx_rst_q <= 1'b0;
      tx_rst_q <= 1'b0;
    end
    else
    begin
      rx_rst_q <= 1'b0;
      tx_rst_q <= 1'b0;
      if (wr_go)
      begin
        unique case (paddr)
          ADDR_LINE_FORMAT_CONTROL: lfc_q <= ufc_lfc_t'(pwdata[7:0]);
          ADDR_FIFO_SETUP_CONTROL:
          begin
            fifo_en_q <= pwdata[FSC_EN];
            if (pwdata[FSC_EN])
            begin
              rx_rst_q <= pwdata[FSC_RX_RST];
              tx_rst_q <= pwdata[FSC_TX_RST];
              rx_code_q <= pwdata[FSC_RX_LSB +: 2];
              if (efe_q[EFE_ENH_BIT])
                tx_code_q <= pwdata[FSC_TX_LSB +: 2];
            end
          end
          ADDR_FEATURE_TABLE_CONTROL:
          begin
            tbl_q <= pwdata[FTC_TBL_LSB +: 2];
            ftc_dest_q <= pwdata[FTC_TRG_DEST];
          end
          ADDR_PROGRAMMABLE_TRIGGER_LEVEL:
          begin
            if (ftc_dest_q)
              prog_q.tx <= pwdata[7:0];
            else
              prog_q.rx <= pwdata[7:0];
          end
          ADDR_ENHANCED_FUNCTION_ENABLE: efe_q <= pwdata[7:0];
          ADDR_IRQ_MASK: imask_q <= pwdata[IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO pointers and counts
  // ----------------------------------------------------------------
  logic [FIFO_AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic [7:0] tx_rdata_q, rx_data;

  assign tx_push = wr_go && (paddr == ADDR_DATA) && (tx_cnt_q != FIFO_DEPTH);
  assign rx_pop = rd_go && (paddr == ADDR_DATA) && rx_avail_q;

  // Transmit FIFO bookkeeping
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= 7'h00;
    end
    else if (tx_rst_q)
    begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= 7'h00;
    end
    else
    begin
      tx_wp_q <= tx_wp_q + FIFO_AW'(tx_push);
      tx_rp_q <= tx_rp_q + FIFO_AW'(tx_pop);
      tx_cnt_q <= tx_cnt_q + 7'(tx_push) - 7'(tx_pop);
    end
  end

  // Receive FIFO bookkeeping
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= 7'h00;
      rx_avail_q <= 1'b0;
    end
    else if (rx_rst_q)
    begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= 7'h00;
      rx_avail_q <= 1'b0;
    end
    else
    begin
      rx_wp_q <= rx_wp_q + FIFO_AW'(rx_push);
      rx_rp_q <= rx_rp_q + FIFO_AW'(rx_pop);
      rx_cnt_q <= rx_cnt_q + 7'(rx_push) - 7'(rx_pop);
      rx_avail_q <= (rx_cnt_q != 7'h00) && !rx_pop; // lags the store by one cycle
    end
  end

  ufc_fifo_mem u_tx_mem
  (
    .clk(clk),
    .we(tx_push),
    .waddr(tx_wp_q),
    .wdata(pwdata[7:0]),
    .raddr(tx_rp_q),
    .rdata_q(tx_rdata_q)
  );

  ufc_fifo_mem u_rx_mem
  (
    .clk(clk),
    .we(rx_push),
    .waddr(rx_wp_q),
    .wdata(rx_data),
    .raddr(rx_rp_q),
    .rdata_q(rx_rdata_q)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  ufc_tx_st_t tx_st_q;
  logic [7:0] tx_sh_q;
  logic [5:0] tx_tk_q;
  logic [2:0] tx_bit_q;
  logic tx_par_q;
  logic [5:0] stop_ticks;

  assign tx_pop = (tx_st_q == TX_IDLE) && (tx_cnt_q != 7'h00) && !tx_rst_q;
  assign tx_busy = (tx_st_q != TX_IDLE);
  // Half-extra stop only for 5-bit words
  assign stop_ticks = !lfc_q.stop_long ? TICKS_BIT :
                      (lfc_q.wlen == 2'h0) ? TICKS_STOP15 : TICKS_STOP2;

  // Frame sequencer, LSB first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 8'h00;
      tx_tk_q <= 6'h00;
      tx_bit_q <= 3'h0;
      tx_par_q <= 1'b0;
      txd <= 1'b1;
    end
    else
    begin
      unique case (tx_st_q)
        TX_IDLE:
        begin
          txd <= 1'b1;
          if (tx_pop)
            tx_st_q <= TX_LOAD;
        end
        TX_LOAD:
        begin
          tx_sh_q <= tx_rdata_q;
          tx_par_q <= ufc_parity(tx_rdata_q, lfc_q);
          tx_tk_q <= 6'h3f; // Parked: start bit waits for a tick
          tx_bit_q <= 3'h0;
          tx_st_q <= TX_START;
        end
        TX_START:
        begin
          if (tick_q)
          begin
            tx_tk_q <= tx_tk_q + 6'h01;
            if (tx_tk_q == 6'h3f)
              txd <= 1'b0; // Full-length start bit
            if (tx_tk_q == TICKS_BIT - 6'h01)
            begin
              tx_tk_q <= 6'h00;
              txd <= tx_sh_q[0];
              tx_st_q <= TX_DATA;
            end
          end
        end
        TX_DATA:
        begin
          if (tick_q)
          begin
            tx_tk_q <= tx_tk_q + 6'h01;
            if (tx_tk_q == TICKS_BIT - 6'h01)
            begin
              tx_tk_q <= 6'h00;
              tx_sh_q <= tx_sh_q >> 1;
              tx_bit_q <= tx_bit_q + 3'h1;
              if (tx_bit_q == {1'b1, lfc_q.wlen})
              begin
                // Last data bit done: parity or stops
                txd <= lfc_q.par_en ? tx_par_q : 1'b1;
                tx_st_q <= lfc_q.par_en ? TX_PAR : TX_STOP;
              end
              else
                txd <= tx_sh_q[1];
            end
          end
        end
        TX_PAR:
        begin
          if (tick_q)
          begin
            tx_tk_q <= tx_tk_q + 6'h01;
            if (tx_tk_q == TICKS_BIT - 6'h01)
            begin
              tx_tk_q <= 6'h00;
              txd <= 1'b1;
              tx_st_q <= TX_STOP;
            end
          end
        end
        TX_STOP:
        begin
          if (tick_q)
          begin
            tx_tk_q <= tx_tk_q + 6'h01;
            if (tx_tk_q == stop_ticks - 6'h01)
              tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  ufc_rx_st_t rx_st_q;
  logic [7:0] rx_sh_q;
  logic [5:0] rx_tk_q;
  logic [2:0] rx_bit_q;
  logic rx_par_q, rx_done, mid;

  assign mid = tick_q && (rx_tk_q == TICKS_BIT - 6'h01);
  assign rx_data = rx_sh_q >> (2'h3 - lfc_q.wlen);
  assign rx_done = (rx_st_q == RX_STOP) && mid;
  assign rx_push = rx_done && (rx_cnt_q != FIFO_DEPTH) && !rx_rst_q;

  // Frame sampler at bit centres
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= 8'h00;
      rx_tk_q <= 6'h00;
      rx_bit_q <= 3'h0;
      rx_par_q <= 1'b0;
    end
    else
    begin
      if (tick_q)
        rx_tk_q <= rx_tk_q + 6'h01;
      unique case (rx_st_q)
        RX_IDLE:
        begin
          rx_tk_q <= 6'h00;
          rx_bit_q <= 3'h0;
          if (!rxd_s_q)
            rx_st_q <= RX_START;
        end
        RX_START:
        begin
          if (tick_q && rx_tk_q == TICKS_HALF - 6'h01)
          begin
            rx_tk_q <= 6'h00;
            rx_st_q <= rxd_s_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (mid)
          begin
            rx_tk_q <= 6'h00;
            rx_sh_q <= {rxd_s_q, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == {1'b1, lfc_q.wlen})
              rx_st_q <= lfc_q.par_en ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR:
        begin
          if (mid)
          begin
            rx_tk_q <= 6'h00;
            rx_par_q <= rxd_s_q;
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (mid)
            rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events, sticky status and mask
  // ----------------------------------------------------------------
  logic rx_hit_q, tx_low_q, tx_over_q, tx_pop_seen_q;
  logic rx_hit, tx_low;

  assign rx_hit = {1'b0, rx_cnt_q} >= rx_trig;
  assign tx_low = {1'b0, tx_cnt_q} < tx_trig;
  // Event sources
  always_comb
  begin
    iset = '0;
    iset[IRQ_RX_TRIG] = rx_hit && !rx_hit_q;
    iset[IRQ_TX_TRIG] = (tx_low && !tx_low_q && tx_over_q) ||
                        (tx_cnt_q == 7'h00 && tx_low_q && !tx_over_q && tx_pop_seen_q);
    iset[IRQ_PAR_ERR] = rx_done && lfc_q.par_en && (rx_par_q != ufc_parity(rx_data, lfc_q));
    iset[IRQ_FRM_ERR] = rx_done && !rxd_s_q;
    iset[IRQ_OVERRUN] = rx_done && (rx_cnt_q == FIFO_DEPTH);
  end

  // Level history for crossing detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_hit_q <= 1'b0;
      tx_low_q <= 1'b1;
      tx_over_q <= 1'b0;
      tx_pop_seen_q <= 1'b0;
    end
    else
    begin
      rx_hit_q <= rx_hit;
      tx_low_q <= tx_low;
      if (!tx_low)
        tx_over_q <= 1'b1;
      else if (tx_cnt_q == 7'h00)
        tx_over_q <= 1'b0;
      // Armed by a reload, spent when the FIFO drains empty
      if (tx_push)
        tx_pop_seen_q <= 1'b1;
      else if (tx_cnt_q == 7'h00)
        tx_pop_seen_q <= 1'b0;
    end
  end

  // Sticky bits, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      ist_q <= (ist_q & ~((wr_go && paddr == ADDR_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : '0)) | iset;
      irq <= |(ist_q & imask_q);
    end
  end
endmodule : ufc_top
`default_nettype wire

// ---- common/ufc_pkg.sv ----
// Purpose: Shared constants and types for the UART trigger and frame format block
// Assumes: 40 MHz clock, APB register access, 32-bit data words
// Notes: Offsets are byte addresses of aligned words
package ufc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00; // Write: tx FIFO, read: rx FIFO
  localparam logic [7:0] ADDR_LINE_FORMAT_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_FIFO_SETUP_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_FEATURE_TABLE_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_PROGRAMMABLE_TRIGGER_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_ENHANCED_FUNCTION_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_LEVEL_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FSC_EN = 0;
  localparam int FSC_RX_RST = 1;
  localparam int FSC_TX_RST = 2;
  localparam int FSC_TX_LSB = 4;
  localparam int FSC_RX_LSB = 6;
  localparam int FTC_TBL_LSB = 4;
  localparam int FTC_TRG_DEST = 7;
  localparam int EFE_ENH_BIT = 4;
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [7:0] TRIG_RESET = 8'h01;
  localparam int IRQ_RX_TRIG = 0;
  localparam int IRQ_TX_TRIG = 1;
  localparam int IRQ_PAR_ERR = 2;
  localparam int IRQ_FRM_ERR = 3;
  localparam int IRQ_OVERRUN = 4;
  localparam int IRQ_W = 5;

  // ----------------------------------------------------------------
  // FIFO geometry and timing
  // ----------------------------------------------------------------
  localparam int FIFO_AW = 6;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam int OVS = 16;
  localparam logic [4:0] TICK_DIV = 5'(CLK_HZ / (BAUD_HZ * OVS));
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_STOP15 = 6'h18;
  localparam logic [5:0] TICKS_STOP2 = 6'h20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] spare;
    logic force_par;
    logic par_even;
    logic par_en;
    logic stop_long;
    logic [1:0] wlen;
  } ufc_lfc_t;

  typedef struct packed {
    logic [7:0] rx;
    logic [7:0] tx;
  } ufc_trig_t;

  typedef enum logic [1:0] {TBL_A, TBL_B, TBL_C, TBL_PROG} ufc_tbl_t;
endpackage : ufc_pkg

// ---- design/ufc_fifo_mem.sv ----
// Purpose: Character store for one FIFO direction
// Assumes: One write and one read port on the same clock
// Notes: Read data is registered, one cycle after the address
`timescale 1ns/10ps
`default_nettype none
module ufc_fifo_mem
(
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [ufc_pkg::FIFO_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [ufc_pkg::FIFO_AW-1:0] raddr,
  output logic [7:0] rdata_q
);
  import ufc_pkg::*;

  logic [7:0] mem [0:(1<<FIFO_AW)-1];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk)
  begin
    rdata_q <= mem[raddr];
  end
endmodule : ufc_fifo_mem
`default_nettype wire

// ---- bench/ufc_top_properties.sv ----
// Purpose: Port checks for ufc_top
// Assumes: One clock, APB with one wait state
// Notes: Bound from the testbench
`timescale 1ns/10ps
`default_nettype none
module ufc_top_properties
  import ufc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and interrupt
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (pready && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped address not refused");
  a_mapped_no_err: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped address refused");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_mask_off_quiet: assert property (pready && pwrite && paddr == ADDR_IRQ_MASK &&
    pwdata[4:0] == 5'h0 |=> ##1 !irq)
    else $error("irq with all masked");
  a_start_bit_low: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  a_idle_after_reset: assert property ($rose(resetn) |-> txd && !irq)
    else $error("line or irq not idle after reset");
endmodule : ufc_top_properties
`default_nettype wire

// ---- bench/ufc_line_model.sv ----
// Purpose: Remote serial device on the line
// Assumes: 336 clocks per bit
// Notes: Line idles high between frames
`timescale 1ns/10ps
`default_nettype none
module ufc_line_model
(
  // Clock
  input wire logic clk,
  // Line
  input wire logic txd,
  output logic rxd
);
  localparam int BT = 336; // Clocks per bit
  initial rxd = 1'b1;
  // Frame out bit 0 first, then idle high
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd <= f[i];
      repeat (BT) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send
  // Sample 12 bits mid bit after a start edge
  task automatic recv(output logic [11:0] f);
    int t;
    t = 0;
    f = '1;
    while (txd !== 1'b0 && t < 9000)
    begin
      @(posedge clk);
      t++;
    end
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < 12; i++)
    begin
      f[i] = txd;
      repeat (BT) @(posedge clk);
    end
  endtask : recv
endmodule : ufc_line_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for ufc_top
// Assumes: 40 MHz clock, line model on rxd and txd
// Notes: Frames are judged bit by bit
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ufc_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] got;
  int n_mismatch, checked;
  ufc_top DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .irq(irq));
  ufc_line_model line (.clk(clk), .txd(txd), .rxd(rxd));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check
  // One APB transfer; read data and error kept
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (t >= 50)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask : apb
  // Expected frame: start, data, parity, stops
  function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d);
    int n;
    logic p;
    logic [11:0] b;
    n = 5 + int'(f[1:0]);
    p = f[5] ? ~f[4] : (^(d & 8'((9'h1 << n) - 9'h1))) ^ ~f[4];
    b = 12'hffe;
    for (int i = 0; i < n; i++)
      b[i + 1] = d[i];
    if (f[3])
      b[n + 1] = p;
    return b;
  endfunction : frame
  task automatic tx_frame(input logic [7:0] f);
    apb(1'b1, ADDR_LINE_FORMAT_CONTROL, {24'h0, f});
    apb(1'b0, ADDR_LINE_FORMAT_CONTROL, 32'h0);
    check(rd, {24'h0, f});
    apb(1'b1, ADDR_DATA, 32'hb5);
    line.recv(got);
    check(got, frame(f, 8'hb5));
  endtask : tx_frame
  // Start to start of two queued frames
  task automatic stop_gap(input logic [7:0] f, input int e);
    int c;
    apb(1'b1, ADDR_LINE_FORMAT_CONTROL, {24'h0, f});
    apb(1'b1, ADDR_DATA, 32'hff);
    apb(1'b1, ADDR_DATA, 32'hff);
    c = 0;
    while (txd !== 1'b0 && c < 9000)
    begin
      @(posedge clk);
      c++;
    end
    c = 0;
    while (txd !== 1'b1 && c < 9000)
    begin
      @(posedge clk);
      c++;
    end
    while (txd !== 1'b0 && c < 9000)
    begin
      @(posedge clk);
      c++;
    end
    check(c >= e && c <= e + 24, 1'b1);
    repeat (3400) @(posedge clk);
  endtask : stop_gap
  // Receive until the trigger level, then clear the status and read back
  task automatic rx_trig(input logic [7:0] tbl, input logic [7:0] fsc, input int lvl);
    apb(1'b1, ADDR_LINE_FORMAT_CONTROL, 32'h03);
    apb(1'b1, ADDR_FEATURE_TABLE_CONTROL, {24'h0, tbl});
    apb(1'b1, ADDR_PROGRAMMABLE_TRIGGER_LEVEL, 32'h3);
    apb(1'b1, ADDR_FIFO_SETUP_CONTROL, {24'h0, fsc});
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1f);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    for (int i = 1; i <= lvl; i++)
    begin
      line.send(frame(8'h03, 8'(i)), 10);
      repeat (40) @(posedge clk);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      check(rd[0], i == lvl);
    end
    check(irq, 1'b1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    for (int i = 1; i <= lvl; i++)
    begin
      apb(1'b0, ADDR_DATA, 32'h0);
      check(rd, i);
    end
  endtask : rx_trig
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, ADDR_LINE_FORMAT_CONTROL, 32'h0);
    check(rd, {24'h0, LFC_RESET});
    apb(1'b0, 8'h24, 32'h0);
    check(err, 1'b1);
    foreach (got[i])
      if (i < 8)
        tx_frame(i[0] ? {2'h0, 3'(i), 3'h3} : {2'h0, 3'(i), 3'h2});
    stop_gap(8'h04, 2520);
    stop_gap(8'h05, 3024);
    rx_trig(8'h30, 8'h01, 3);
    rx_trig(8'h00, 8'h41, 4);
    complete_run();
  end
endmodule : testbench
bind ufc_top ufc_top_properties chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
`default_nettype wire
